//--- rtl/stt_pkg.sv
/*
  shared constants, carriers and helpers of the system timer block
  assumes a 32-bit apb bus and one 10 mhz system clock
*/
package stt_pkg;

    // ====================================================================
    // register indexes, byte address is four times the index
    localparam logic [7:0] IDX_T4_COUNT_LOW = 8'hac;
    localparam logic [7:0] IDX_T4_COUNT_HIGH = 8'had;
    localparam logic [7:0] IDX_T3_COUNT_LOW = 8'hae;
    localparam logic [7:0] IDX_T3_COUNT_HIGH = 8'haf;
    localparam logic [7:0] IDX_T2_CONTROL = 8'hc8;
    localparam logic [7:0] IDX_T2_RELOAD_LOW = 8'hca;
    localparam logic [7:0] IDX_T2_RELOAD_HIGH = 8'hcb;
    localparam logic [7:0] IDX_T2_COUNT_LOW = 8'hcc;
    localparam logic [7:0] IDX_T2_COUNT_HIGH = 8'hcd;
    localparam logic [7:0] IDX_T34_CONTROL = 8'hcf;

    // ====================================================================
    // timer two control fields
    localparam int T2_OVF_FLAG_BIT = 7;
    localparam int T2_EXT_FLAG_BIT = 6;
    localparam int T2_RX_CLK_SEL_BIT = 5;
    localparam int T2_TX_CLK_SEL_BIT = 4;
    localparam int T2_EXT_EN_BIT = 3;
    localparam int T2_RUN_BIT = 2;
    localparam int T2_COUNTER_SEL_BIT = 1;
    localparam int T2_CAPTURE_SEL_BIT = 0;

    // ====================================================================
    // timer three and four control fields
    localparam int T4_FLAG_BIT = 7;
    localparam int T4_MODE_BIT = 6;
    localparam int T4_RUN_BIT = 5;
    localparam int T4_IRQ_EN_BIT = 4;
    localparam int T3_FLAG_BIT = 3;
    localparam int T3_MODE_BIT = 2;
    localparam int T3_RUN_BIT = 1;
    localparam int T3_IRQ_EN_BIT = 0;

    // ====================================================================
    // reset values and timing
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;
    localparam logic [3:0] T2_TIMER_DIV_LAST = 4'hb;
    localparam logic [3:0] T2_BAUD_DIV_LAST = 4'h1;

    // ====================================================================
    // carriers
    typedef struct packed {
        logic [31:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } stt_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } stt_apb_rsp_t;

    typedef struct packed {
        logic [15:0] count;
        logic [15:0] reload;
    } stt_simple_state_t;

    typedef struct packed {
        logic meta;
        logic stable;
        logic last;
    } stt_sync_state_t;

    typedef struct packed {
        logic [15:0] t2_count;
        logic [15:0] t2_reload;
        logic [7:0] t2_ctrl;
        logic [7:0] t34_ctrl;
        logic [3:0] presc;
        logic uart_rx;
        logic uart_tx;
        logic [31:0] prdata;
        logic pslverr;
    } stt_main_state_t;

    // ====================================================================
    // helpers
    function automatic logic stt_hit(input logic [31:0] addr, input logic [7:0] idx);
        stt_hit = (addr == {22'h000000, idx, 2'b00});
    endfunction : stt_hit

    function automatic logic [15:0] stt_set_byte(input logic [15:0] word, input logic high,
                                                 input logic [7:0] data);
        stt_set_byte = high ? {data, word[7:0]} : {word[15:8], data};
    endfunction : stt_set_byte

endpackage : stt_pkg

//--- rtl/stt_pin_sync.sv
/*
  two-flop synchroniser with falling edge detect for the shared timer two pin
  assumes the pin is asynchronous to clock_i
*/
`timescale 1ns/10ps
module stt_pin_sync (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic pin_i,
    output logic level_o,
    output logic fall_o
);
    import stt_pkg::*;

    stt_sync_state_t st_q;
    stt_sync_state_t st_d;

    // ====================================================================
    // sampling chain, meta read only by stable
    always_comb begin
        st_d = st_q;
        st_d.meta = pin_i;
        st_d.stable = st_q.meta;
        st_d.last = st_q.stable;
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '{meta: 1'b1, stable: 1'b1, last: 1'b1};
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.stable;
    assign fall_o = st_q.last & ~st_q.stable;

endmodule : stt_pin_sync

//--- rtl/stt_simple_timer.sv
/*
  one 16-bit reload or free-run timer clocked every system clock
  assumes run, mode and byte writes come from the same clock domain
*/
`timescale 1ns/10ps
module stt_simple_timer (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic run_i,
    input wire logic reload_mode_i,
    input wire logic wr_low_i,
    input wire logic wr_high_i,
    input wire logic [7:0] wdata_i,
    output logic [15:0] count_o,
    output logic overflow_o
);
    import stt_pkg::*;

    stt_simple_state_t st_q;
    stt_simple_state_t st_d;
    logic ovf;

    // ====================================================================
    // counting and byte writes
    always_comb begin
        st_d = st_q;
        ovf = run_i & (st_q.count == COUNT_ALL_ONES);
        if (run_i) begin
            if (ovf) begin
                st_d.count = reload_mode_i ? st_q.reload : COUNT_RESET;
            end else begin
                st_d.count = 16'(st_q.count + 16'h0001);
            end
        end
        if (wr_low_i | wr_high_i) begin
            if (reload_mode_i) begin
                st_d.reload = stt_set_byte(st_q.reload, wr_high_i, wdata_i);
            end else begin
                st_d.count = stt_set_byte(st_d.count, wr_high_i, wdata_i);
            end
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '{count: COUNT_RESET, reload: COUNT_RESET};
        end else begin
            st_q <= st_d;
        end
    end

    assign count_o = st_q.count;
    assign overflow_o = ovf;

    // ====================================================================
    // checks
    AST_ST_HOLD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (!run_i && !wr_low_i && !wr_high_i) |=> $stable(st_q.count))
        else $error("simple timer moved while stopped");

    AST_ST_WRAP: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (ovf && !reload_mode_i && !wr_low_i && !wr_high_i) |=> st_q.count == 16'h0000)
        else $error("free-run timer did not wrap to zero");

    AST_ST_FREE_WRITE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (wr_low_i && !wr_high_i && !reload_mode_i) |=> st_q.count[7:0] == $past(wdata_i))
        else $error("free-run write did not load counter");

endmodule : stt_simple_timer

//--- rtl/stt_timers.sv
/*
  system timers two, three and four with an apb register slave
  assumes apb master on clock_i, timer one overflow pulse on clock_i,
  shared timer two pin asynchronous
*/
// Our own choice: the APB register port.
`timescale 1ns/10ps
module stt_timers (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire stt_pkg::stt_apb_req_t apb_req_i,
    output stt_pkg::stt_apb_rsp_t apb_rsp_o,
    input wire logic timer_two_pin_i,
    input wire logic timer_one_overflow_i,
    output logic uart_rx_clock_o,
    output logic uart_tx_clock_o,
    output logic timer_two_irq_o,
    output logic timer_three_irq_o,
    output logic timer_four_irq_o
);
    import stt_pkg::*;

    stt_main_state_t st_q;
    stt_main_state_t st_d;

    logic pin_fall;
    logic baud;
    logic cap_mode;
    logic run;
    logic ctr_sel;
    logic t2_tick;
    logic t2_ovf;
    logic trig;
    logic wr_en;
    logic hit_any;
    logic [7:0] wbyte;
    logic wr_t2ctrl;
    logic wr_t34ctrl;
    logic wr_t2cnt_l;
    logic wr_t2cnt_h;
    logic wr_t2rld_l;
    logic wr_t2rld_h;
    logic wr_t3_l;
    logic wr_t3_h;
    logic wr_t4_l;
    logic wr_t4_h;
    logic [15:0] t3_count;
    logic [15:0] t4_count;
    logic t3_ovf;
    logic t4_ovf;
    logic [7:0] rd_byte;
    logic [3:0] div_last;
    logic t2_slow;

    // ====================================================================
    // shared pin, count input and trigger both
    stt_pin_sync u_pin_sync (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .pin_i(timer_two_pin_i),
        .level_o(),
        .fall_o(pin_fall)
    );

    // ====================================================================
    // apb decode
    assign wr_en = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & apb_req_i.pstrb[0];
    assign wbyte = apb_req_i.pwdata[7:0];
    assign wr_t2ctrl = wr_en & stt_hit(apb_req_i.paddr, IDX_T2_CONTROL);
    assign wr_t34ctrl = wr_en & stt_hit(apb_req_i.paddr, IDX_T34_CONTROL);
    assign wr_t2cnt_l = wr_en & stt_hit(apb_req_i.paddr, IDX_T2_COUNT_LOW);
    assign wr_t2cnt_h = wr_en & stt_hit(apb_req_i.paddr, IDX_T2_COUNT_HIGH);
    assign wr_t2rld_l = wr_en & stt_hit(apb_req_i.paddr, IDX_T2_RELOAD_LOW);
    assign wr_t2rld_h = wr_en & stt_hit(apb_req_i.paddr, IDX_T2_RELOAD_HIGH);
    assign wr_t3_l = wr_en & stt_hit(apb_req_i.paddr, IDX_T3_COUNT_LOW);
    assign wr_t3_h = wr_en & stt_hit(apb_req_i.paddr, IDX_T3_COUNT_HIGH);
    assign wr_t4_l = wr_en & stt_hit(apb_req_i.paddr, IDX_T4_COUNT_LOW);
    assign wr_t4_h = wr_en & stt_hit(apb_req_i.paddr, IDX_T4_COUNT_HIGH);

    // read mux, live counts without snapshot
    always_comb begin
        rd_byte = 8'h00;
        hit_any = 1'b1;
        if (stt_hit(apb_req_i.paddr, IDX_T2_CONTROL)) begin
            rd_byte = st_q.t2_ctrl;
        end else if (stt_hit(apb_req_i.paddr, IDX_T34_CONTROL)) begin
            rd_byte = st_q.t34_ctrl;
        end else if (stt_hit(apb_req_i.paddr, IDX_T2_COUNT_LOW)) begin
            rd_byte = st_q.t2_count[7:0];
        end else if (stt_hit(apb_req_i.paddr, IDX_T2_COUNT_HIGH)) begin
            rd_byte = st_q.t2_count[15:8];
        end else if (stt_hit(apb_req_i.paddr, IDX_T2_RELOAD_LOW)) begin
            rd_byte = st_q.t2_reload[7:0];
        end else if (stt_hit(apb_req_i.paddr, IDX_T2_RELOAD_HIGH)) begin
            rd_byte = st_q.t2_reload[15:8];
        end else if (stt_hit(apb_req_i.paddr, IDX_T3_COUNT_LOW)) begin
            rd_byte = t3_count[7:0];
        end else if (stt_hit(apb_req_i.paddr, IDX_T3_COUNT_HIGH)) begin
            rd_byte = t3_count[15:8];
        end else if (stt_hit(apb_req_i.paddr, IDX_T4_COUNT_LOW)) begin
            rd_byte = t4_count[7:0];
        end else if (stt_hit(apb_req_i.paddr, IDX_T4_COUNT_HIGH)) begin
            rd_byte = t4_count[15:8];
        end else begin
            hit_any = 1'b0;
        end
    end

    // ====================================================================
    // timer two mode decode
    assign baud = st_q.t2_ctrl[T2_RX_CLK_SEL_BIT] | st_q.t2_ctrl[T2_TX_CLK_SEL_BIT];
    assign cap_mode = st_q.t2_ctrl[T2_CAPTURE_SEL_BIT] & ~baud;
    assign run = st_q.t2_ctrl[T2_RUN_BIT];
    assign ctr_sel = st_q.t2_ctrl[T2_COUNTER_SEL_BIT];
    assign div_last = baud ? T2_BAUD_DIV_LAST : T2_TIMER_DIV_LAST;
    assign t2_slow = run & ~ctr_sel & ~baud;
    assign trig = st_q.t2_ctrl[T2_EXT_EN_BIT] & pin_fall;
    assign t2_ovf = t2_tick & (st_q.t2_count == COUNT_ALL_ONES);

    // tick source, prescaler or pin
    always_comb begin
        t2_tick = 1'b0;
        if (run && ctr_sel) begin
            t2_tick = pin_fall;
        end else if (run) begin
            t2_tick = (st_q.presc >= div_last);
        end
    end

    // ====================================================================
    // next state
    always_comb begin
        st_d = st_q;
        // prescaler
        if (run && !ctr_sel && !t2_tick) begin
            st_d.presc = 4'(st_q.presc + 4'h1);
        end else begin
            st_d.presc = 4'h0;
        end
        // timer two count
        if (t2_tick) begin
            if (t2_ovf) begin
                st_d.t2_count = cap_mode ? COUNT_RESET : st_q.t2_reload;
            end else begin
                st_d.t2_count = 16'(st_q.t2_count + 16'h0001);
            end
        end
        if (trig && !baud) begin
            if (cap_mode) begin
                st_d.t2_reload = st_q.t2_count;
            end else begin
                st_d.t2_count = st_q.t2_reload;
            end
        end
        if (wr_t2cnt_l || wr_t2cnt_h) begin
            st_d.t2_count = stt_set_byte(st_d.t2_count, wr_t2cnt_h, wbyte);
        end
        if (wr_t2rld_l || wr_t2rld_h) begin
            st_d.t2_reload = stt_set_byte(st_q.t2_reload, wr_t2rld_h, wbyte);
        end
        // control registers, hardware set wins over clear
        if (wr_t2ctrl) begin
            st_d.t2_ctrl = wbyte;
        end
        if (t2_ovf && !baud) begin
            st_d.t2_ctrl[T2_OVF_FLAG_BIT] = 1'b1;
        end
        if (trig) begin
            st_d.t2_ctrl[T2_EXT_FLAG_BIT] = 1'b1;
        end
        if (wr_t34ctrl) begin
            st_d.t34_ctrl = wbyte;
        end
        if (t3_ovf) begin
            st_d.t34_ctrl[T3_FLAG_BIT] = 1'b1;
        end
        if (t4_ovf) begin
            st_d.t34_ctrl[T4_FLAG_BIT] = 1'b1;
        end
        // uart baud pulses
        st_d.uart_rx = st_q.t2_ctrl[T2_RX_CLK_SEL_BIT] ? t2_ovf : timer_one_overflow_i;
        st_d.uart_tx = st_q.t2_ctrl[T2_TX_CLK_SEL_BIT] ? t2_ovf : timer_one_overflow_i;
        // apb read data captured in setup phase
        if (apb_req_i.psel && !apb_req_i.penable) begin
            st_d.prdata = {24'h000000, rd_byte};
            st_d.pslverr = ~hit_any;
        end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_q <= '{t2_count: COUNT_RESET, t2_reload: COUNT_RESET, t2_ctrl: CTRL_RESET,
                      t34_ctrl: CTRL_RESET, presc: 4'h0, uart_rx: 1'b0, uart_tx: 1'b0,
                      prdata: 32'h00000000, pslverr: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    // ====================================================================
    // timers three and four
    stt_simple_timer u_timer_three (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .run_i(st_q.t34_ctrl[T3_RUN_BIT]),
        .reload_mode_i(st_q.t34_ctrl[T3_MODE_BIT]),
        .wr_low_i(wr_t3_l),
        .wr_high_i(wr_t3_h),
        .wdata_i(wbyte),
        .count_o(t3_count),
        .overflow_o(t3_ovf)
    );

    stt_simple_timer u_timer_four (
        .clock_i(clock_i),
        .rst_b_i(rst_b_i),
        .run_i(st_q.t34_ctrl[T4_RUN_BIT]),
        .reload_mode_i(st_q.t34_ctrl[T4_MODE_BIT]),
        .wr_low_i(wr_t4_l),
        .wr_high_i(wr_t4_h),
        .wdata_i(wbyte),
        .count_o(t4_count),
        .overflow_o(t4_ovf)
    );

    // ====================================================================
    // outputs
    assign apb_rsp_o.prdata = st_q.prdata;
    assign apb_rsp_o.pready = 1'b1;
    assign apb_rsp_o.pslverr = st_q.pslverr & apb_req_i.psel & apb_req_i.penable;
    assign uart_rx_clock_o = st_q.uart_rx;
    assign uart_tx_clock_o = st_q.uart_tx;
    assign timer_two_irq_o = st_q.t2_ctrl[T2_OVF_FLAG_BIT] | st_q.t2_ctrl[T2_EXT_FLAG_BIT];
    assign timer_three_irq_o = st_q.t34_ctrl[T3_FLAG_BIT] & st_q.t34_ctrl[T3_IRQ_EN_BIT];
    assign timer_four_irq_o = st_q.t34_ctrl[T4_FLAG_BIT] & st_q.t34_ctrl[T4_IRQ_EN_BIT];

    // ====================================================================
    // checks
    AST_T2_RELOAD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (t2_ovf && !cap_mode && !wr_t2cnt_l && !wr_t2cnt_h)
        |=> st_q.t2_count == $past(st_q.t2_reload))
        else $error("timer two did not reload on overflow");

    AST_T2_TRIG_RELOAD: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (trig && !cap_mode && !baud && !wr_t2cnt_l && !wr_t2cnt_h)
        |=> st_q.t2_count == $past(st_q.t2_reload))
        else $error("trigger did not reload timer two");

    AST_T2_FLAG: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (t2_ovf && !baud) |=> st_q.t2_ctrl[T2_OVF_FLAG_BIT])
        else $error("timer two overflow flag not set");

    AST_T2_BAUD_NOFLAG: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (t2_ovf && baud && !st_q.t2_ctrl[T2_OVF_FLAG_BIT] && !wr_t2ctrl)
        |=> !st_q.t2_ctrl[T2_OVF_FLAG_BIT])
        else $error("baud overflow set timer two flag");

    AST_T2_CAPTURE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (trig && cap_mode && !wr_t2rld_l && !wr_t2rld_h)
        |=> st_q.t2_reload == $past(st_q.t2_count))
        else $error("capture did not copy count");

    AST_T2_EXT_FLAG: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        trig |=> st_q.t2_ctrl[T2_EXT_FLAG_BIT])
        else $error("external flag not set on trigger");

    AST_T2_EXT_IGNORED: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (pin_fall && !st_q.t2_ctrl[T2_EXT_EN_BIT] && !run && !wr_t2ctrl
         && !wr_t2cnt_l && !wr_t2cnt_h && !wr_t2rld_l && !wr_t2rld_h)
        |=> $stable(st_q.t2_ctrl) && $stable(st_q.t2_count) && $stable(st_q.t2_reload))
        else $error("trigger acted while disabled");

    AST_T2_STOPPED: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (!run && !trig && !wr_t2cnt_l && !wr_t2cnt_h) |=> $stable(st_q.t2_count))
        else $error("timer two moved while stopped");

    AST_UART_RX: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        1'b1 |=> uart_rx_clock_o == ($past(st_q.t2_ctrl[T2_RX_CLK_SEL_BIT])
                                     ? $past(t2_ovf) : $past(timer_one_overflow_i)))
        else $error("uart receive clock source wrong");

    AST_UART_TX: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        1'b1 |=> uart_tx_clock_o == ($past(st_q.t2_ctrl[T2_TX_CLK_SEL_BIT])
                                     ? $past(t2_ovf) : $past(timer_one_overflow_i)))
        else $error("uart transmit clock source wrong");

    AST_T2_PIN_TICK: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (t2_tick && ctr_sel) |-> pin_fall)
        else $error("counter mode ticked without pin edge");

    AST_T2_PIN_COUNT: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (run && ctr_sel && pin_fall && !trig && st_q.t2_count != COUNT_ALL_ONES
         && !wr_t2cnt_l && !wr_t2cnt_h)
        |=> st_q.t2_count == 16'($past(st_q.t2_count) + 16'h0001))
        else $error("counter mode missed a pin edge");

    AST_T2_BAUD_RATE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (run && !ctr_sel && baud && !wr_t2ctrl && t2_tick)
        |=> !t2_tick ##1 (t2_tick || wr_t2ctrl || $past(wr_t2ctrl)))
        else $error("baud prescaler not two clocks");

    AST_T2_TIMER_RATE: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (t2_slow && t2_tick) ##1 t2_slow [*8] ##1 t2_slow [*3]
        |=> (t2_tick || !t2_slow))
        else $error("timer prescaler not twelve clocks");

    AST_T34_FLAGS: assert property (@(posedge clock_i) disable iff (!rst_b_i)
        (t3_ovf || t4_ovf) |=> (st_q.t34_ctrl[T3_FLAG_BIT] || !$past(t3_ovf))
                               && (st_q.t34_ctrl[T4_FLAG_BIT] || !$past(t4_ovf)))
        else $error("timer three or four flag not set");

    COV_BAUD_OVF: cover property (@(posedge clock_i) disable iff (!rst_b_i) t2_ovf && baud);
    COV_TIMER_OVF: cover property (@(posedge clock_i) disable iff (!rst_b_i)
        t2_ovf && t2_slow);
    COV_CAPTURE: cover property (@(posedge clock_i) disable iff (!rst_b_i) trig && cap_mode);
    COV_RELOAD_TRIG: cover property (@(posedge clock_i) disable iff (!rst_b_i)
        trig && !cap_mode && !baud);
    COV_T3_IRQ: cover property (@(posedge clock_i) disable iff (!rst_b_i) $rose(timer_three_irq_o));

endmodule : stt_timers

//--- dv/stt_far_side.sv
/*
  far side model: shared timer two pin and timer one overflow pulse
  assumes bench raises fall_i just after a rising edge
*/
`timescale 1ns/10ps
module stt_far_side (
    input wire logic clock_i,
    input wire logic fall_i,
    output logic pin_o = 1'b1,
    output logic t1_ovf_o = 1'b0
);
    logic [2:0] div_q = 3'h0;
    // ====================================================================
    // pin idles high, low while a fall is requested
    always @(posedge clock_i) begin
        div_q <= div_q + 3'h1;
        t1_ovf_o <= (div_q == 3'h7);
        pin_o <= ~fall_i;
    end
endmodule : stt_far_side

//--- dv/tb.sv
/*
  self-checking bench of the system timers over apb
  assumes the far side model drives the pin and timer one pulse
*/
`timescale 1ns/10ps
module tb;
    import stt_pkg::*;
    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic fall = 1'b0;
    logic pin, t1o, rxc, txc, i2, i3, i4, se;
    logic [7:0] rd;
    logic [7:0] regs [6] = '{IDX_T4_COUNT_LOW, IDX_T4_COUNT_HIGH, IDX_T3_COUNT_LOW,
        IDX_T3_COUNT_HIGH, IDX_T2_CONTROL, IDX_T34_CONTROL};
    stt_apb_req_t rq = '0;
    stt_apb_rsp_t rs;
    int err_count = 0;
    int cmp_count = 0;
    always #50 clock_i = ~clock_i;
    stt_far_side far (.clock_i(clock_i), .fall_i(fall), .pin_o(pin), .t1_ovf_o(t1o));
    stt_timers dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .apb_req_i(rq), .apb_rsp_o(rs),
        .timer_two_pin_i(pin), .timer_one_overflow_i(t1o), .uart_rx_clock_o(rxc),
        .uart_tx_clock_o(txc), .timer_two_irq_o(i2), .timer_three_irq_o(i3),
        .timer_four_irq_o(i4));
    // ====================================================================
    // tasks
    task automatic conclude();
        $display("tb: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
        int n = 0;
        @(posedge clock_i);
        rq.paddr <= {22'h0, idx, 2'b00};
        rq.psel <= 1'b1;
        rq.pwrite <= wr;
        rq.pwdata <= {24'h0, d};
        rq.pstrb <= 4'hf;
        @(posedge clock_i);
        rq.penable <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (rs.pready !== 1'b1 && n < 50);
        rd = rs.prdata[7:0];
        se = rs.pslverr;
        rq.psel <= 1'b0;
        rq.penable <= 1'b0;
        if (rs.pready !== 1'b1) begin
            err_count++;
            conclude();
        end
    endtask : apb
    task automatic waitfor(ref logic s);
        for (int n = 0; n < 200 && s !== 1'b1; n++) begin
            @(negedge clock_i);
        end
        chk({7'h0, s}, 8'h01);
        if (s !== 1'b1) begin
            conclude();
        end
    endtask : waitfor
    task automatic trig();
        fall <= 1'b1;
        repeat (4) @(posedge clock_i);
        fall <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask : trig
    // ====================================================================
    // tests
    initial begin
        repeat (5) @(posedge clock_i);
        rst_b_i <= 1'b1;
        foreach (regs[k]) begin
            apb(1'b0, regs[k], 8'h00);
            chk(rd, CTRL_RESET);
        end
        apb(1'b0, 8'h10, 8'h00);
        chk({7'h0, se}, 8'h01);
        chk(rd, 8'h00);
        $display("tb: reset and map test done");
        apb(1'b1, IDX_T3_COUNT_HIGH, 8'hff);
        apb(1'b1, IDX_T3_COUNT_LOW, 8'hf0);
        apb(1'b0, IDX_T3_COUNT_HIGH, 8'h00);
        chk(rd, 8'hff);
        apb(1'b1, IDX_T34_CONTROL, 8'h03);
        waitfor(i3);
        apb(1'b0, IDX_T3_COUNT_HIGH, 8'h00);
        chk(rd, 8'h00);
        apb(1'b0, IDX_T34_CONTROL, 8'h00);
        chk(rd, 8'h0b);
        apb(1'b1, IDX_T34_CONTROL, 8'h08);
        @(negedge clock_i);
        chk({7'h0, i3}, 8'h00);
        $display("tb: timer three test done");
        apb(1'b1, IDX_T4_COUNT_HIGH, 8'hff);
        apb(1'b1, IDX_T4_COUNT_LOW, 8'hfe);
        apb(1'b1, IDX_T34_CONTROL, 8'h40);
        apb(1'b1, IDX_T4_COUNT_HIGH, 8'h12);
        apb(1'b0, IDX_T4_COUNT_HIGH, 8'h00);
        chk(rd, 8'hff);
        apb(1'b1, IDX_T34_CONTROL, 8'h70);
        waitfor(i4);
        apb(1'b0, IDX_T4_COUNT_HIGH, 8'h00);
        chk(rd, 8'h12);
        apb(1'b1, IDX_T34_CONTROL, 8'h00);
        $display("tb: timer four test done");
        apb(1'b1, IDX_T2_COUNT_LOW, 8'h34);
        apb(1'b1, IDX_T2_COUNT_HIGH, 8'h12);
        apb(1'b1, IDX_T2_CONTROL, 8'h09);
        trig();
        waitfor(i2);
        apb(1'b0, IDX_T2_RELOAD_HIGH, 8'h00);
        chk(rd, 8'h12);
        apb(1'b0, IDX_T2_CONTROL, 8'h00);
        chk(rd, 8'h49);
        apb(1'b1, IDX_T2_CONTROL, 8'h01);
        trig();
        chk({7'h0, i2}, 8'h00);
        $display("tb: timer two capture test done");
        apb(1'b1, IDX_T2_RELOAD_LOW, 8'hff);
        apb(1'b1, IDX_T2_RELOAD_HIGH, 8'hff);
        apb(1'b1, IDX_T2_COUNT_LOW, 8'hff);
        apb(1'b1, IDX_T2_COUNT_HIGH, 8'hff);
        apb(1'b1, IDX_T2_CONTROL, 8'h04);
        waitfor(i2);
        apb(1'b0, IDX_T2_CONTROL, 8'h00);
        chk(rd, 8'h84);
        apb(1'b1, IDX_T2_CONTROL, 8'h04);
        @(negedge clock_i);
        waitfor(i2);
        apb(1'b1, IDX_T2_CONTROL, 8'h24);
        repeat (3) @(negedge clock_i);
        waitfor(rxc);
        @(negedge clock_i);
        chk({7'h0, rxc}, 8'h00);
        @(negedge clock_i);
        chk({7'h0, rxc}, 8'h01);
        waitfor(txc);
        repeat (2) @(negedge clock_i);
        chk({7'h0, txc}, 8'h00);
        apb(1'b0, IDX_T2_CONTROL, 8'h00);
        chk(rd, 8'h24);
        $display("tb: timer two reload and baud test done");
        apb(1'b1, IDX_T2_CONTROL, 8'h00);
        apb(1'b1, IDX_T2_RELOAD_LOW, 8'h00);
        apb(1'b1, IDX_T2_CONTROL, 8'h06);
        trig();
        trig();
        apb(1'b0, IDX_T2_COUNT_LOW, 8'h00);
        chk(rd, 8'h01);
        apb(1'b1, IDX_T2_CONTROL, 8'h08);
        trig();
        apb(1'b0, IDX_T2_COUNT_LOW, 8'h00);
        chk(rd, 8'h00);
        apb(1'b0, IDX_T2_CONTROL, 8'h00);
        chk(rd, 8'h48);
        $display("tb: timer two counter and trigger test done");
        conclude();
    end
endmodule : tb
